/* rxbui_cal_page.sv */
// rxbui_cal_page: one 16-bit page of the flow-control calendar.
// assumes the load strobe is already qualified by the page pointer.
`timescale 1ns/1ns
module rxbui_cal_page
    import rxbui_pkg::*;
(
    input  wire logic                  MCLK,
    input  wire logic                  NRST,
    input  wire logic                  LOAD,
    input  wire logic [CAL_PAGE_W-1:0] BITS_IN,
    output      logic [CAL_PAGE_W-1:0] PAGE
);

    logic [CAL_PAGE_W-1:0] page_q;

    // holds its bits until the same page comes round again
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            page_q <= '0;
        end else if (LOAD) begin
            page_q <= BITS_IN;
        end
    end

    assign PAGE = page_q;

endmodule

/* rxbui_pkg.sv */
// rxbui_pkg: constants shared by the receive burst user interface block.
// assumes one clock domain (MCLK, 100 MHz) and eight 64-bit words per symbol.
package rxbui_pkg;

    // symbol geometry: eight words of 64 bits
    localparam int unsigned WORD_W    = 64;
    localparam int unsigned NUM_WORDS = 8;
    localparam int unsigned DATA_W    = WORD_W * NUM_WORDS;
    localparam int unsigned CNT_W     = 4;
    localparam int unsigned NVAL_W    = 2 * CNT_W;

    // calendar: pages of 16 flow-control bits; legal page counts are 1, 2, 4, 8, 16
    localparam int unsigned CAL_PAGE_W = 16;
    localparam int unsigned CAL_PAGES  = 4;
    localparam int unsigned CAL_PTR_W  = 4;
    localparam int unsigned CAL_W      = CAL_PAGE_W * CAL_PAGES;

    // position flag codes
    localparam logic [1:0] POS_NONE = 2'h0;
    localparam logic [1:0] POS_B63  = 2'h2;
    localparam logic [1:0] POS_B31  = 2'h1;

    // packet end codes
    localparam logic [3:0] EOP_NONE  = 4'h0;
    localparam logic [3:0] EOP_ERROR = 4'h1;
    localparam logic       EOP_GOOD  = 1'b1;

    // valid word counts
    localparam logic [CNT_W-1:0] NV_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] NV_FULL = 4'h8;
    localparam logic [CNT_W-1:0] NV_HALF = 4'h4;

    // register bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_W  = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CLEAR   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_PKT_CNT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_ERR_CNT = 8'h14;

    // control and event bit positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned EV_W        = 4;
    localparam int unsigned EV_PKT_OK   = 0;
    localparam int unsigned EV_PKT_ERR  = 1;
    localparam int unsigned EV_CAL_DONE = 2;
    localparam int unsigned EV_FRAMING  = 3;

    // reset values
    localparam logic [REG_W-1:0] CTRL_RST   = 32'h0000_0001;
    localparam logic [EV_W-1:0]  EV_RST     = 4'h0;
    localparam logic [REG_W-1:0] CNT_RST    = 32'h0000_0000;
    localparam logic [REG_W-1:0] RDATA_ZERO = 32'h0000_0000;

endpackage

/* rxbui_properties.sv */
// rxbui_properties: concurrent checks on the receive user outputs of rxbui_top.
// assumes one clock, MCLK, and the async active-low NRST; sees top ports only.
`timescale 1ns/1ns
module rxbui_chk
    import rxbui_pkg::*;
(
    input wire logic                  MCLK,
    input wire logic                  NRST,
    input wire logic                  LNK_VALID,
    input wire logic [DATA_W-1:0]     LNK_WORDS,
    input wire logic [CNT_W-1:0]      LNK_NUM_VALID,
    input wire logic [NUM_WORDS-1:0]  LNK_IDLE,
    input wire logic [NUM_WORDS-1:0]  LNK_CTRL,
    input wire logic                  LNK_SOB_B63,
    input wire logic                  LNK_SOB_B31,
    input wire logic                  LNK_SOP_B63,
    input wire logic                  LNK_SOP_B31,
    input wire logic                  LNK_EOB,
    input wire logic                  LNK_EOP,
    input wire logic                  LNK_EOP_ERR,
    input wire logic [2:0]            LNK_EOP_BYTES,
    input wire logic                  LNK_FC_VALID,
    input wire logic                  LNK_FC_FIRST,
    input wire logic [CAL_PAGE_W-1:0] LNK_FC_BITS,
    input wire logic [DATA_W-1:0]     RX_DOUT_WORDS,
    input wire logic [NVAL_W-1:0]     RX_NUM_VALID,
    input wire logic [1:0]            RX_SOB,
    input wire logic [1:0]            RX_SOP,
    input wire logic                  RX_EOB,
    input wire logic [3:0]            RX_EOPBITS,
    input wire logic                  RX_ERR,
    input wire logic [CAL_W-1:0]      RX_CALENDAR,
    input wire logic [ADDR_W-1:0]     REG_ADDR,
    input wire logic [REG_W-1:0]      REG_WDATA,
    input wire logic                  REG_WR
);
    logic en_q;
    logic take;
    // shadow of the path enable, so refused symbols do not trip the checks
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) en_q <= 1'b1;
        else if (REG_WR && REG_ADDR == REG_CTRL) en_q <= REG_WDATA[CTRL_EN_BIT];
    end
    assign take = LNK_VALID && en_q;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    a_sob_top: assert property (take && LNK_SOB_B63 |=> RX_SOB == POS_B63)
        else $error("burst start at byte 63 not flagged");
    a_sob_half: assert property (take && !LNK_SOB_B63 && LNK_SOB_B31
        |=> RX_SOB == POS_B31)
        else $error("burst start at byte 31 not flagged");
    a_sop_half: assert property (take && !LNK_SOP_B63 && LNK_SOP_B31
        |=> RX_SOP == POS_B31)
        else $error("packet start at byte 31 not flagged");
    a_idle_zero: assert property (!take |=> RX_NUM_VALID == 8'h00 && RX_SOB == POS_NONE
        && RX_SOP == POS_NONE && !RX_EOB)
        else $error("empty cycle shows count or flags");
    a_count_full: assert property (take && LNK_NUM_VALID == NV_FULL
        |=> RX_NUM_VALID == {NV_FULL, NV_HALF})
        else $error("full symbol count wrong");
    a_word_order: assert property (take && LNK_IDLE == '0 && LNK_CTRL == '0
        |=> RX_DOUT_WORDS == $past(LNK_WORDS))
        else $error("data words not in order");
    a_lane_mask: assert property (take && LNK_IDLE[0] |=> RX_DOUT_WORDS[63:0] == '0)
        else $error("idle lane not blanked");
    a_eop_good: assert property (take && LNK_EOP && !LNK_EOP_ERR
        |=> RX_EOPBITS == {EOP_GOOD, $past(LNK_EOP_BYTES)})
        else $error("good end code wrong");
    a_eob_mark: assert property (take && LNK_EOB |=> RX_EOB)
        else $error("burst end lost");
    a_err_eob: assert property (RX_ERR |-> RX_EOB && RX_EOPBITS == EOP_ERROR)
        else $error("error flag outside a burst end");
    a_cal_first: assert property (LNK_FC_VALID && LNK_FC_FIRST
        |=> RX_CALENDAR[CAL_W-1 -: CAL_PAGE_W] == $past(LNK_FC_BITS))
        else $error("first calendar page not loaded");
endmodule
bind rxbui_top rxbui_chk u_chk (.*);

/* rxbui_top.sv */
// rxbui_top: receive burst user interface, presents decoded symbols to user logic.
// assumes the link side hands over one decoded symbol per cycle on MCLK,
// with per-word idle/control marks, and control words for the calendar.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
module rxbui_top
    import rxbui_pkg::*;
(
    input  wire logic                 MCLK,
    input  wire logic                 NRST,
    // decoded symbol from the link side
    input  wire logic                 LNK_VALID,
    input  wire logic [DATA_W-1:0]    LNK_WORDS,
    input  wire logic [CNT_W-1:0]     LNK_NUM_VALID,
    input  wire logic [NUM_WORDS-1:0] LNK_IDLE,
    input  wire logic [NUM_WORDS-1:0] LNK_CTRL,
    input  wire logic                 LNK_SOB_B63,
    input  wire logic                 LNK_SOB_B31,
    input  wire logic                 LNK_SOP_B63,
    input  wire logic                 LNK_SOP_B31,
    input  wire logic                 LNK_EOB,
    input  wire logic                 LNK_EOP,
    input  wire logic                 LNK_EOP_ERR,
    input  wire logic [2:0]           LNK_EOP_BYTES,
    // control words carrying calendar bits
    input  wire logic                 LNK_FC_VALID,
    input  wire logic                 LNK_FC_FIRST,
    input  wire logic [CAL_PAGE_W-1:0] LNK_FC_BITS,
    // user data side
    output      logic [DATA_W-1:0]    RX_DOUT_WORDS,
    output      logic [NVAL_W-1:0]    RX_NUM_VALID,
    output      logic [1:0]           RX_SOB,
    output      logic [1:0]           RX_SOP,
    output      logic                 RX_EOB,
    output      logic [3:0]           RX_EOPBITS,
    output      logic                 RX_ERR,
    output      logic [CAL_W-1:0]     RX_CALENDAR,
    // register port
    input  wire logic [ADDR_W-1:0]    REG_ADDR,
    input  wire logic [REG_W-1:0]     REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output      logic [REG_W-1:0]     REG_RDATA,
    output      logic                 IRQ
);

    // software-visible state
    logic [REG_W-1:0] ctrl_q;
    logic [EV_W-1:0]  status_q;
    logic [EV_W-1:0]  irq_en_q;
    logic [REG_W-1:0] pkt_cnt_q;
    logic [REG_W-1:0] err_cnt_q;
    logic [REG_W-1:0] rdata_q;

    // output registers
    logic [DATA_W-1:0] dout_q;
    logic [NVAL_W-1:0] nval_q;
    logic [1:0]        sob_q;
    logic [1:0]        sop_q;
    logic              eob_q;
    logic [3:0]        eopbits_q;
    logic              err_q;

    // calendar pointer and framing tracker
    logic [CAL_PTR_W-1:0] cal_ptr_q;
    logic [CAL_PTR_W-1:0] cal_ptr_d;
    logic [CAL_PTR_W-1:0] cal_slot;
    logic                 cal_done;
    logic                 in_pkt_q;

    // combinational values for the next symbol
    logic                 take;
    logic [DATA_W-1:0]    dout_d;
    logic [NVAL_W-1:0]    nval_d;
    logic [1:0]           sob_d;
    logic [1:0]           sop_d;
    logic [3:0]           eopbits_d;
    logic                 ev_ok;
    logic                 ev_err;
    logic                 ev_framing;
    logic [EV_W-1:0]      ev_vec;
    logic [EV_W-1:0]      clr_vec;
    logic                 any_sop;

    // the symbol is passed on only while software has the path enabled
    // a refused symbol still clears the outputs, so nothing stale is shown twice
    assign take    = LNK_VALID & ctrl_q[CTRL_EN_BIT];
    assign any_sop = LNK_SOP_B63 | LNK_SOP_B31;

    // word masking: idle and control words are zeroed so nothing stale leaks out
    always_comb begin
        dout_d = '0;
        for (int i = 0; i < NUM_WORDS; i++) begin
            // word 0 of the symbol sits in the top lane, the last in the bottom lane
            if (take && !LNK_IDLE[NUM_WORDS-1-i] && !LNK_CTRL[NUM_WORDS-1-i]) begin
                dout_d[(NUM_WORDS-1-i)*WORD_W +: WORD_W] =
                    LNK_WORDS[(NUM_WORDS-1-i)*WORD_W +: WORD_W];
            end
        end
    end

    // valid word count: upper nibble for the full bus, lower for the low half
    // the lower nibble reads four only for a full count of eight, and zero for any other count
    always_comb begin
        nval_d = {NV_ZERO, NV_ZERO};
        if (take) begin
            nval_d[NVAL_W-1:CNT_W] = LNK_NUM_VALID;
            if (LNK_NUM_VALID == NV_FULL) begin
                nval_d[CNT_W-1:0] = NV_HALF;
            end
        end
    end

    // start positions; byte 63 wins if the link ever flags both
    always_comb begin
        sob_d = POS_NONE;
        sop_d = POS_NONE;
        if (take) begin
            if (LNK_SOB_B63) begin
                sob_d = POS_B63;
            end else if (LNK_SOB_B31) begin
                sob_d = POS_B31;
            end
            if (LNK_SOP_B63) begin
                sop_d = POS_B63;
            end else if (LNK_SOP_B31) begin
                sop_d = POS_B31;
            end
        end
    end

    // packet end code; an error end carries no byte count
    always_comb begin
        eopbits_d = EOP_NONE;
        if (take && LNK_EOP) begin
            if (LNK_EOP_ERR) begin
                eopbits_d = EOP_ERROR;
            end else begin
                eopbits_d = {EOP_GOOD, LNK_EOP_BYTES};
            end
        end
    end

    // events seen on accepted symbols
    assign ev_ok      = take & LNK_EOP & ~LNK_EOP_ERR;
    assign ev_err     = take & LNK_EOP & LNK_EOP_ERR;
    // packet end outside a packet, or a second start inside one
    // only reported: the symbol still goes out, user logic decides what to drop
    assign ev_framing = take &
                        ((LNK_EOP & ~in_pkt_q & ~any_sop) | (any_sop & in_pkt_q & ~LNK_EOP));

    // data path registers: every user output changes only on the clock edge
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            dout_q    <= '0;
            nval_q    <= '0;
            sob_q     <= POS_NONE;
            sop_q     <= POS_NONE;
            eopbits_q <= EOP_NONE;
        end else begin
            dout_q    <= dout_d;
            nval_q    <= nval_d;
            sob_q     <= sob_d;
            sop_q     <= sop_d;
            eopbits_q <= eopbits_d;
        end
    end

    // burst end and packet error; the error is only raised beside a burst end
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            eob_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            eob_q <= take & LNK_EOB;
            err_q <= take & LNK_EOB & LNK_EOP & LNK_EOP_ERR;
        end
    end

    // packet tracker for the framing check
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            in_pkt_q <= 1'b0;
        end else if (take) begin
            if (LNK_EOP) begin
                // a start after an end in the same symbol opens a new packet
                in_pkt_q <= any_sop & (LNK_SOP_B31 | ~LNK_SOP_B63);
            end else if (any_sop) begin
                in_pkt_q <= 1'b1;
            end
        end
    end

    // calendar page pointer: restarts on the first control word of a round
    // the slot is found first, so that a one-page calendar wraps as well
    always_comb begin
        cal_slot  = LNK_FC_FIRST ? '0 : cal_ptr_q;
        cal_ptr_d = cal_ptr_q;
        cal_done  = 1'b0;
        if (LNK_FC_VALID) begin
            if (cal_slot == CAL_PTR_W'(CAL_PAGES - 1)) begin
                cal_ptr_d = '0;
            end else begin
                cal_ptr_d = cal_slot + CAL_PTR_W'(1);
            end
            // the round is complete when the last page is written
            cal_done = (cal_slot == CAL_PTR_W'(CAL_PAGES - 1));
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cal_ptr_q <= '0;
        end else begin
            cal_ptr_q <= cal_ptr_d;
        end
    end

    // one page register per calendar page; the bus runs free of the data valid
    for (genvar p = 0; p < CAL_PAGES; p++) begin : g_page
        logic load_p;
        // page 0 is the most significant slice, so the first control word lands on top
        assign load_p = LNK_FC_VALID &&
                        (cal_slot == CAL_PTR_W'(p));
        rxbui_cal_page u_page (
            .MCLK    (MCLK),
            .NRST    (NRST),
            .LOAD    (load_p),
            .BITS_IN (LNK_FC_BITS),
            .PAGE    (RX_CALENDAR[(CAL_PAGES-1-p)*CAL_PAGE_W +: CAL_PAGE_W])
        );
    end

    // control register: bit 0 opens the data path
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= CTRL_RST;
        end else if (REG_WR && REG_ADDR == REG_CTRL) begin
            ctrl_q <= REG_WDATA;
        end
    end

    // interrupt enable register, same layout as status
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_en_q <= EV_RST;
        end else if (REG_WR && REG_ADDR == REG_IRQ_EN) begin
            irq_en_q <= REG_WDATA[EV_W-1:0];
        end
    end

    // sticky status; an event in the clearing cycle survives the clear
    // a one in the clear word removes only that bit, zeros leave the rest alone
    always_comb begin
        ev_vec              = '0;
        ev_vec[EV_PKT_OK]   = ev_ok;
        ev_vec[EV_PKT_ERR]  = ev_err;
        ev_vec[EV_CAL_DONE] = cal_done;
        ev_vec[EV_FRAMING]  = ev_framing;
        clr_vec             = (REG_WR && REG_ADDR == REG_CLEAR) ? REG_WDATA[EV_W-1:0] : '0;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            status_q <= EV_RST;
        end else begin
            status_q <= (status_q & ~clr_vec) | ev_vec;
        end
    end

    // packet counters; a write of any value zeroes them, unless a packet ends then
    // they wrap silently: software is expected to read them often enough
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pkt_cnt_q <= CNT_RST;
        end else if (ev_ok) begin
            pkt_cnt_q <= (REG_WR && REG_ADDR == REG_PKT_CNT) ? REG_W'(1) : pkt_cnt_q + REG_W'(1);
        end else if (REG_WR && REG_ADDR == REG_PKT_CNT) begin
            pkt_cnt_q <= CNT_RST;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            err_cnt_q <= CNT_RST;
        end else if (ev_err) begin
            err_cnt_q <= (REG_WR && REG_ADDR == REG_ERR_CNT) ? REG_W'(1) : err_cnt_q + REG_W'(1);
        end else if (REG_WR && REG_ADDR == REG_ERR_CNT) begin
            err_cnt_q <= CNT_RST;
        end
    end

    // read data stands one cycle after the strobe and only there
    // reads have no side effects, so polling the status never loses an event
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= RDATA_ZERO;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                REG_CTRL:    rdata_q <= ctrl_q;
                REG_STATUS:  rdata_q <= {{(REG_W-EV_W){1'b0}}, status_q};
                REG_IRQ_EN:  rdata_q <= {{(REG_W-EV_W){1'b0}}, irq_en_q};
                REG_PKT_CNT: rdata_q <= pkt_cnt_q;
                REG_ERR_CNT: rdata_q <= err_cnt_q;
                // clear register is write-only; unmapped reads return zero
                default:     rdata_q <= RDATA_ZERO;
            endcase
        end else begin
            rdata_q <= RDATA_ZERO;
        end
    end

    // outputs
    assign RX_DOUT_WORDS = dout_q;
    assign RX_NUM_VALID  = nval_q;
    assign RX_SOB        = sob_q;
    assign RX_SOP        = sop_q;
    assign RX_EOB        = eob_q;
    assign RX_EOPBITS    = eopbits_q;
    assign RX_ERR        = err_q;
    assign REG_RDATA     = rdata_q;
    // level interrupt, combinational from two registers
    // it drops on the same edge that writes the clear or enable register
    assign IRQ           = |(status_q & irq_en_q);

endmodule

/* rxbui_top_tb_top.sv */
// rxbui_top_tb_top: directed bench for the receive burst user interface.
// assumes the one-cycle answer of the data path and of register reads.
`timescale 1ns/1ns
module rxbui_top_tb_top
    import rxbui_pkg::*;
;
    logic MCLK, NRST, LNK_VALID, LNK_SOB_B63, LNK_SOB_B31, LNK_SOP_B63, LNK_SOP_B31;
    logic LNK_EOB, LNK_EOP, LNK_EOP_ERR, LNK_FC_VALID, LNK_FC_FIRST, REG_WR, REG_RD, IRQ;
    logic RX_EOB, RX_ERR;
    logic [DATA_W-1:0] LNK_WORDS, RX_DOUT_WORDS, pat, msk;
    logic [CNT_W-1:0] LNK_NUM_VALID;
    logic [NUM_WORDS-1:0] LNK_IDLE, LNK_CTRL;
    logic [2:0] LNK_EOP_BYTES;
    logic [CAL_PAGE_W-1:0] LNK_FC_BITS;
    logic [NVAL_W-1:0] RX_NUM_VALID;
    logic [1:0] RX_SOB, RX_SOP;
    logic [3:0] RX_EOPBITS;
    logic [CAL_W-1:0] RX_CALENDAR;
    logic [ADDR_W-1:0] REG_ADDR;
    logic [REG_W-1:0] REG_WDATA, REG_RDATA, rv;
    logic [7:0] word_cnt, good_cnt, bad_cnt;
    int err_count, checks_done;
    rxbui_top u_dut (.*);
    rxbui_user_sink u_sink (.MCLK(MCLK), .NRST(NRST), .RX_NUM_VALID(RX_NUM_VALID),
        .RX_EOB(RX_EOB), .RX_EOPBITS(RX_EOPBITS), .RX_ERR(RX_ERR),
        .word_cnt(word_cnt), .good_cnt(good_cnt), .bad_cnt(bad_cnt));
    // free-running 100 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // register access: one strobe cycle, read data the cycle after
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1;
        rv = REG_RDATA;
    endtask
    // one symbol; flags are sob63 sob31 sop63 sop31 eob eop err
    task automatic sym(input logic [3:0] nv, input logic [7:0] idl, input logic [7:0] ctl,
                       input logic [6:0] f, input logic [2:0] nb);
        @(posedge MCLK);
        LNK_VALID <= 1'b1;
        LNK_WORDS <= pat;
        LNK_NUM_VALID <= nv;
        LNK_IDLE <= idl;
        LNK_CTRL <= ctl;
        {LNK_SOB_B63, LNK_SOB_B31, LNK_SOP_B63, LNK_SOP_B31, LNK_EOB, LNK_EOP, LNK_EOP_ERR} <= f;
        LNK_EOP_BYTES <= nb;
        @(posedge MCLK);
        LNK_VALID <= 1'b0;
        {LNK_SOB_B63, LNK_SOB_B31, LNK_SOP_B63, LNK_SOP_B31, LNK_EOB, LNK_EOP, LNK_EOP_ERR} <= '0;
        #1;
    endtask
    // hang guard at 2000 cycles, far beyond the roughly 65 cycles the sequence needs
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
    initial begin
        {NRST, LNK_VALID, LNK_SOB_B63, LNK_SOB_B31, LNK_SOP_B63, LNK_SOP_B31} = '0;
        {LNK_EOB, LNK_EOP, LNK_EOP_ERR, LNK_FC_VALID, LNK_FC_FIRST, REG_WR, REG_RD} = '0;
        {LNK_NUM_VALID, LNK_IDLE, LNK_CTRL, LNK_EOP_BYTES, LNK_FC_BITS, REG_ADDR, REG_WDATA} = '0;
        LNK_WORDS = '0;
        for (int i = 0; i < NUM_WORDS; i++) pat[DATA_W-1-64*i -: 64] = 64'h0123_4567_89AB_CD00 | i;
        msk = pat;
        msk[63:0] = '0;
        msk[DATA_W-1 -: 64] = '0;
        repeat (3) @(posedge MCLK);
        NRST <= 1'b1;
        rd(REG_CTRL);
        chk("ctrl", CTRL_RST, rv);
        sym(NV_FULL, 8'h00, 8'h00, 7'b1010000, 3'h0);
        chk("count", 8'h84, RX_NUM_VALID);
        chk("sob", POS_B63, RX_SOB);
        chk("sop", POS_B63, RX_SOP);
        chk("data", pat, RX_DOUT_WORDS);
        sym(NV_FULL, 8'h00, 8'h00, 7'b0000110, 3'h3);
        chk("eob", 1'b1, RX_EOB);
        chk("eop good", 4'hB, RX_EOPBITS);
        chk("err low", 1'b0, RX_ERR);
        sym(NV_HALF, 8'h01, 8'h80, 7'b0101000, 3'h0);
        chk("half count", 8'h40, RX_NUM_VALID);
        chk("sob half", POS_B31, RX_SOB);
        chk("sop half", POS_B31, RX_SOP);
        chk("masked", msk, RX_DOUT_WORDS);
        sym(NV_FULL, 8'h00, 8'h00, 7'b0000111, 3'h0);
        chk("eop err", EOP_ERROR, RX_EOPBITS);
        chk("err high", 2'b11, {RX_ERR, RX_EOB});
        @(posedge MCLK);
        #1;
        chk("empty", 12'h000, {RX_NUM_VALID, RX_SOB, RX_SOP});
        // five back-to-back control words: the fifth wraps onto page 0
        for (int i = 0; i < 5; i++) begin
            @(posedge MCLK);
            LNK_FC_VALID <= 1'b1;
            LNK_FC_FIRST <= (i == 0);
            LNK_FC_BITS <= 16'hA1A1 + 16'(i) * 16'h1111;
        end
        @(posedge MCLK);
        LNK_FC_VALID <= 1'b0;
        #1;
        chk("calendar", 64'hE5E5_B2B2_C3C3_D4D4, RX_CALENDAR);
        rd(REG_STATUS);
        chk("status", 4'h7, rv[3:0]);
        rd(REG_PKT_CNT);
        chk("pkt cnt", 32'h0000_0001, rv);
        rd(REG_ERR_CNT);
        chk("err cnt", 32'h0000_0001, rv);
        rd(8'h40);
        chk("unmapped", RDATA_ZERO, rv);
        wr(REG_IRQ_EN, 32'h0000_0001);
        chk("irq on", 1'b1, IRQ);
        wr(REG_IRQ_EN, 32'h0000_0000);
        chk("irq masked", 1'b0, IRQ);
        wr(REG_IRQ_EN, 32'h0000_0001);
        wr(REG_CLEAR, 32'h0000_0007);
        chk("irq cleared", 1'b0, IRQ);
        rd(REG_STATUS);
        chk("status clr", 3'h0, rv[2:0]);
        // a packet end with no packet open is a framing event; a count write zeroes
        sym(NV_FULL, 8'h00, 8'h00, 7'b0000110, 3'h0);
        rd(REG_STATUS);
        chk("status framing", 4'h9, rv[3:0]);
        rd(REG_PKT_CNT);
        chk("pkt cnt two", 32'h0000_0002, rv);
        wr(REG_PKT_CNT, 32'h0000_0000);
        rd(REG_PKT_CNT);
        chk("pkt cnt zeroed", CNT_RST, rv);
        // a disabled path refuses symbols
        wr(REG_CTRL, 32'h0000_0000);
        sym(NV_FULL, 8'h00, 8'h00, 7'b1010000, 3'h0);
        chk("refused", 8'h00, RX_NUM_VALID);
        wr(REG_CTRL, CTRL_RST);
        chk("sink words", 8'd36, word_cnt);
        chk("sink ends", 16'h0201, {good_cnt, bad_cnt});
        chk("bus width", 512, $bits(RX_DOUT_WORDS));
        // second reset in mid-run: control, counters and the interrupt return to rest
        wr(REG_CTRL, 32'h0000_0000);
        @(posedge MCLK);
        NRST <= 1'b0;
        repeat (3) @(posedge MCLK);
        NRST <= 1'b1;
        #1;
        chk("irq reset", 1'b0, IRQ);
        rd(REG_CTRL);
        chk("ctrl reset", CTRL_RST, rv);
        rd(REG_ERR_CNT);
        chk("err cnt reset", CNT_RST, rv);
        finish_test();
    end
endmodule

/* rxbui_user_sink.sv */
// rxbui_user_sink: model of the user logic that consumes received bursts.
// assumes the registered outputs of rxbui_top on the same clock.
`timescale 1ns/1ns
module rxbui_user_sink
    import rxbui_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              NRST,
    input  wire logic [NVAL_W-1:0] RX_NUM_VALID,
    input  wire logic              RX_EOB,
    input  wire logic [3:0]        RX_EOPBITS,
    input  wire logic              RX_ERR,
    output      logic [7:0]        word_cnt,
    output      logic [7:0]        good_cnt,
    output      logic [7:0]        bad_cnt
);
    // tallies of what user logic would keep; data with a zero count is dropped
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            word_cnt <= 8'h00;
            good_cnt <= 8'h00;
            bad_cnt  <= 8'h00;
        end else begin
            if (RX_NUM_VALID[7:4] != 4'h0) word_cnt <= word_cnt + 8'(RX_NUM_VALID[7:4]);
            if (RX_EOB && RX_EOPBITS[3]) good_cnt <= good_cnt + 8'h01;
            if (RX_EOB && RX_ERR) bad_cnt <= bad_cnt + 8'h01;
        end
    end
endmodule
